// File: shared/receive_descriptor_pointer_pkg.sv
// package: constants and types for the receive descriptor pointer block
// assumes a 32-bit plain register port and one 100 MHz core clock
//
// Contract
// - pointer holds descriptor address in bits 31:2
// - pointer follows engine along descriptor list
// - null link leaves pointer on current descriptor
// - receive enable strobe rereads current link field
// - zero pointer plus enable enters silent mode
// - silent mode buffers frames, performs no DMA
// - valid pointer plus enable drains buffered frames
// - pointer is 32-bit read/write, reset clears
package receive_descriptor_pointer_pkg;
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          FIFO_DEPTH    = 16;
  // register offsets (byte addresses)
  localparam logic [7:0]  OFF_CMD       = 8'h04;   // command: receive enable strobe
  localparam logic [7:0]  OFF_RECEIVE_DESCRIPTOR_POINTER      = 8'h30;   // receive descriptor pointer
  localparam logic [7:0]  OFF_STATUS    = 8'h3C;   // engine status
  localparam logic [7:0]  OFF_LINK      = 8'h40;   // link word of fetched descriptor
  // field layout
  localparam int          CMD_RXE_BIT   = 2;
  localparam logic [31:0] PTR_MASK      = 32'hFFFF_FFFC;
  localparam logic [31:0] PTR_RESET     = 32'h0000_0000;
  localparam logic [31:0] NULL_LINK     = 32'h0000_0000;
  localparam int          ST_IDLE_BIT   = 0;
  localparam int          ST_ACTIVE_BIT = 1;
  localparam int          ST_WAIT_BIT   = 2;
  localparam int          ST_SILENT_BIT = 3;
  localparam int          ST_LEVEL_LSB  = 8;
  // receive engine states, one-hot
  typedef enum logic [4:0] {
    RECEIVE_DESCRIPTOR_POINTER_IDLE   = 5'h01,
    RECEIVE_DESCRIPTOR_POINTER_FETCH  = 5'h02,
    RECEIVE_DESCRIPTOR_POINTER_MOVE   = 5'h04,
    RECEIVE_DESCRIPTOR_POINTER_WAIT   = 5'h08,
    RECEIVE_DESCRIPTOR_POINTER_SILENT = 5'h10
  } receive_descriptor_pointer_state_t;
endpackage : receive_descriptor_pointer_pkg

// File: hdl/receive_descriptor_pointer_fifo.sv
// module: receive data fifo, flip-flop storage, valid/ready both sides
// assumes a single clock and asynchronous active-high reset
`timescale 1ns/1ps
module receive_descriptor_pointer_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             sys_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];      // storage array
  logic [AW-1:0]    wr_ptr;           // write index
  logic [AW-1:0]    rd_ptr;           // read index
  logic [AW:0]      count;            // words held
  wire              push = in_valid_i && in_ready_o;
  wire              pop  = out_valid_o && out_ready_i;
  // occupancy after this edge; ready is registered from it so the
  // stream source sees a flop output, not a path through the compare
  wire [AW:0]       next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign level_o     = count;
  // pointers and count
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      // empty after reset, so ready stands high
      in_ready_o <= 1'b1;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
      count      <= next_count;
      in_ready_o <= (next_count != DEPTH[AW:0]);
    end
  end
  // storage, no reset needed on data
  always_ff @(posedge sys_clk_i) begin
    if (push) mem[wr_ptr] <= in_data_i;
  end
endmodule : receive_descriptor_pointer_fifo

// File: hdl/receive_descriptor_pointer_top.sv
// module: receive descriptor pointer logic with its data fifo
// assumes: plain register port, a memory-side read/write master port with
// one-cycle grant handshake (dma_req/dma_ack), incoming frame words on a stream
`timescale 1ns/1ps
module receive_descriptor_pointer_top (
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // incoming frame words
  input  wire logic [31:0] frame_data_i,
  input  wire logic        frame_valid_i,
  input  wire logic        frame_last_i,
  output logic             frame_ready_o,
  // memory master: read of link word or write of data word
  output logic             dma_req_o,
  output logic             dma_write_o,
  output logic      [31:0] dma_addr_o,
  output logic      [31:0] dma_wdata_o,
  input  wire logic        dma_ack_i,
  input  wire logic [31:0] dma_rdata_i,
  // engine state for observers
  output logic             silent_mode_o
);
  receive_descriptor_pointer_pkg::receive_descriptor_pointer_state_t state;           // engine state
  receive_descriptor_pointer_pkg::receive_descriptor_pointer_state_t next_state;      // engine next state
  logic [31:0]           rx_descriptor_pointer; // current descriptor address
  logic [31:0]           link_word;       // last fetched link
  logic [31:0]           rdata;           // read data register
  logic                  req;             // memory request flag
  logic                  wr_kind;         // request is a data write
  logic [31:0]           addr;            // request address
  logic [31:0]           wdata;           // request data
  logic                  silent;          // registered silent flag
  logic                  in_ready;        // fifo fill ready
  logic                  fifo_valid;      // fifo has data
  logic [32:0]           fifo_word;       // data plus last flag
  logic [4:0]            fifo_level;      // fifo occupancy

  // register decode
  wire wr_cmd   = reg_wr_i && (reg_addr_i == receive_descriptor_pointer_pkg::OFF_CMD);
  wire wr_ptr   = reg_wr_i && (reg_addr_i == receive_descriptor_pointer_pkg::OFF_RECEIVE_DESCRIPTOR_POINTER);
  wire rxe_hit  = wr_cmd && reg_wdata_i[receive_descriptor_pointer_pkg::CMD_RXE_BIT];
  wire is_idle  = (state == receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_IDLE);
  wire ptr_null = (rx_descriptor_pointer == receive_descriptor_pointer_pkg::NULL_LINK);
  wire link_null = (dma_rdata_i == receive_descriptor_pointer_pkg::NULL_LINK);
  wire fifo_pop = (state == receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_MOVE) && req && wr_kind && dma_ack_i;

  // read mux, unmapped reads return zero
  wire [31:0] status_word = {16'h0000, 3'h0, fifo_level,
                             4'h0, silent, (state == receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_WAIT),
                             !is_idle, is_idle};
  wire [31:0] rd_mux =
    (reg_addr_i == receive_descriptor_pointer_pkg::OFF_RECEIVE_DESCRIPTOR_POINTER)   ? (rx_descriptor_pointer & receive_descriptor_pointer_pkg::PTR_MASK) :
    (reg_addr_i == receive_descriptor_pointer_pkg::OFF_STATUS) ? status_word :
    (reg_addr_i == receive_descriptor_pointer_pkg::OFF_LINK)   ? link_word : 32'h0000_0000;

  // data fifo; the frame source stalls on its ready
  receive_descriptor_pointer_fifo #(
    .WIDTH (33),
    .DEPTH (receive_descriptor_pointer_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_data_i   ({frame_last_i, frame_data_i}),
    .in_valid_i  (frame_valid_i),
    .in_ready_o  (in_ready),
    .out_data_o  (fifo_word),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .level_o     (fifo_level)
  );

  // next-state logic
  always_comb begin
    next_state = state;
    unique case (state)
      receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_IDLE: begin
        if (rxe_hit) next_state = ptr_null ? receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_SILENT : receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_MOVE;
      end
      receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_SILENT: begin
        if (rxe_hit && !ptr_null) next_state = receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_MOVE;
      end
      receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_MOVE: begin
        // frame end moves on to the link fetch
        if (fifo_pop && fifo_word[32]) next_state = receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_FETCH;
      end
      receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_FETCH: begin
        if (req && !wr_kind && dma_ack_i)
          next_state = link_null ? receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_WAIT : receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_MOVE;
      end
      receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_WAIT: begin
        if (rxe_hit) next_state = receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_FETCH;
      end
      default: next_state = receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) state <= receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_IDLE;
    else           state <= next_state;
  end

  // pointer register
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_descriptor_pointer <= receive_descriptor_pointer_pkg::PTR_RESET;
    end else if (wr_ptr) begin
      rx_descriptor_pointer <= reg_wdata_i & receive_descriptor_pointer_pkg::PTR_MASK;
    end else if (state == receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_FETCH && req && !wr_kind && dma_ack_i
                 && !link_null) begin
      rx_descriptor_pointer <= dma_rdata_i & receive_descriptor_pointer_pkg::PTR_MASK;
    end
  end

  // fetched link capture
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) link_word <= 32'h0000_0000;
    else if (req && !wr_kind && dma_ack_i) link_word <= dma_rdata_i;
  end

  // memory request: one at a time, dropped on ack
  wire start_rd = (state == receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_FETCH) && !req;
  // data writes only in move state, never in silent
  wire start_wr = (state == receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_MOVE) && !req && fifo_valid;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req     <= 1'b0;
      wr_kind <= 1'b0;
      addr    <= 32'h0000_0000;
      wdata   <= 32'h0000_0000;
    end else if (req) begin
      if (dma_ack_i) req <= 1'b0;
    end else if (start_rd || start_wr) begin
      req     <= 1'b1;
      wr_kind <= start_wr;
      addr    <= rx_descriptor_pointer;  // simplified: buffer addressed via descriptor
      wdata   <= fifo_word[31:0];
    end
  end

  // register read data and silent flag
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata  <= 32'h0000_0000;
      silent <= 1'b0;
    end else begin
      rdata  <= reg_rd_i ? rd_mux : 32'h0000_0000;
      silent <= (next_state == receive_descriptor_pointer_pkg::RECEIVE_DESCRIPTOR_POINTER_SILENT);
    end
  end

  assign reg_rdata_o   = rdata;
  assign frame_ready_o = in_ready;
  assign dma_req_o     = req;
  assign dma_write_o   = wr_kind;
  assign dma_addr_o    = addr;
  assign dma_wdata_o   = wdata;
  assign silent_mode_o = silent;
endmodule : receive_descriptor_pointer_top

// File: bench/receive_descriptor_pointer_checker.sv
// checker: port-level properties of the receive pointer block
// assumes one clock domain and the plain register port of receive_descriptor_pointer_top
`timescale 1ns/1ps
module receive_descriptor_pointer_checker (
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        frame_ready_o,
  input wire logic        dma_req_o,
  input wire logic        dma_write_o,
  input wire logic [31:0] dma_addr_o,
  input wire logic        dma_ack_i,
  input wire logic        silent_mode_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  // receive enable write seen on the port
  wire en_wr = reg_wr_i && reg_addr_i == receive_descriptor_pointer_pkg::OFF_CMD
    && reg_wdata_i[receive_descriptor_pointer_pkg::CMD_RXE_BIT];
  silent_quiet_a: assert property (silent_mode_o |-> !dma_req_o)
    else $error("dma request while silent");
  req_hold_a: assert property (dma_req_o && !dma_ack_i |=> dma_req_o
    && $stable(dma_addr_o) && $stable(dma_write_o)) else $error("request not held");
  req_drop_a: assert property (dma_req_o && dma_ack_i |=> !dma_req_o)
    else $error("request not dropped");
  ptr_low_a: assert property (reg_rd_i && reg_addr_i == receive_descriptor_pointer_pkg::OFF_RECEIVE_DESCRIPTOR_POINTER
    |=> reg_rdata_o[1:0] == 2'h0) else $error("pointer low bits set");
  addr_align_a: assert property (dma_req_o |-> dma_addr_o[1:0] == 2'h0)
    else $error("unaligned dma address");
  silent_entry_a: assert property ($rose(silent_mode_o)
    |-> $past(en_wr) || $past(en_wr, 2)) else $error("silent without enable");
  silent_exit_a: assert property ($fell(silent_mode_o)
    |-> $past(en_wr) || $past(en_wr, 2)) else $error("silent left without enable");
  reset_clear_a: assert property ($fell(sys_rst_i)
    |-> !dma_req_o && !silent_mode_o) else $error("outputs not cleared");
  cover property ($rose(silent_mode_o));
  cover property (dma_req_o && !dma_write_o && dma_ack_i);
  cover property (!frame_ready_o);
endmodule : receive_descriptor_pointer_checker
bind receive_descriptor_pointer_top receive_descriptor_pointer_checker i_chk (.sys_clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .frame_ready_o, .dma_req_o, .dma_write_o,
  .dma_addr_o, .dma_ack_i, .silent_mode_o);

// File: bench/receive_descriptor_pointer_mem_model.sv
// partner: host memory answering link reads and data writes
// assumes one request at a time, completed by a one-cycle ack
`timescale 1ns/1ps
module receive_descriptor_pointer_mem_model (
  input  wire logic        sys_clk_i,
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  output logic             ack_o = 1'b0,
  output logic      [31:0] rdata_o = 32'h5A5A_5A5A
);
  logic [31:0] link [logic [31:0]]; // descriptor chain, absent means null
  int          wait_n = 0;          // stall before next ack
  // random stall of 0..3 cycles; read bus toggles outside an ack
  always @(posedge sys_clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (req_i && !ack_o) begin
      if (wait_n == 0) begin
        ack_o <= 1'b1;
        rdata_o <= link.exists(addr_i) ? link[addr_i] : 32'h0;
        wait_n <= $urandom_range(3);
      end else wait_n <= wait_n - 1;
    end
  end
endmodule : receive_descriptor_pointer_mem_model

// File: bench/receive_descriptor_pointer_top_tb_top.sv
// testbench: register, frame and dma traffic with queued expectations
// assumes receive_descriptor_pointer_top, receive_descriptor_pointer_mem_model and the bound checker
`timescale 1ns/1ps
module receive_descriptor_pointer_top_tb_top;
  localparam logic [31:0] RXE_W = 32'h1 << receive_descriptor_pointer_pkg::CMD_RXE_BIT;
  logic        clk = 1'b0, rst = 1'b1, we = 1'b0, re = 1'b0, fv = 1'b0, fl = 1'b0;
  logic [7:0]  ra = 8'h00;
  logic [31:0] wd = 32'h0, fd = 32'h0, rdat, da, dwd, mrd;
  logic        fr, req, dw, ack, sil, rd_q = 1'b0;
  logic [63:0] e;
  logic [31:0] rq [$];  // expected read data
  logic [63:0] mq [$];  // expected dma address and data
  int          num_errors = 0, n_compared = 0;
  always #5 clk = ~clk;
  receive_descriptor_pointer_top i_dut (.sys_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(ra), .reg_wdata_i(wd),
    .reg_wr_i(we), .reg_rd_i(re), .reg_rdata_o(rdat), .frame_data_i(fd), .frame_valid_i(fv),
    .frame_last_i(fl), .frame_ready_o(fr), .dma_req_o(req), .dma_write_o(dw), .dma_addr_o(da),
    .dma_wdata_o(dwd), .dma_ack_i(ack), .dma_rdata_i(mrd), .silent_mode_o(sil));
  receive_descriptor_pointer_mem_model i_mem (.sys_clk_i(clk), .req_i(req), .addr_i(da), .ack_o(ack), .rdata_o(mrd));
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one bus cycle and a gap; a read notes its expected data
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    ra <= a;
    wd <= d;
    we <= w;
    re <= !w;
    if (!w) rq.push_back(d);
    @(posedge clk);
    we <= 1'b0;
    re <= 1'b0;
    @(posedge clk);
  endtask : bus
  // one frame: each word a write at a, then a link read at a
  task automatic send(int n, logic [31:0] a);
    logic r;
    for (int i = 0; i < n; i++) begin
      fd <= $urandom;
      fv <= 1'b1;
      fl <= (i == n - 1);
      do begin
        @(negedge clk);
        r = fr;
        @(posedge clk);
      end while (!r);
      mq.push_back({a, fd});
    end
    fv <= 1'b0;
    fl <= 1'b0;
    mq.push_back({a, 32'h0});
  endtask : send
  task automatic settle();
    for (int i = 0; i < 400 && mq.size() > 0; i++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk("dma_left", mq.size(), 0);
  endtask : settle
  task automatic reset_dut();
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : reset_dut
  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : stop_test
  // results are taken off the queues as they appear
  always @(posedge clk) begin
    rd_q <= re;
    if (rd_q) chk("reg_rdata", rdat, rq.pop_front());
    if (req && ack) begin
      e = mq.pop_front();
      chk("dma_addr", da, e[63:32]);
      if (dw) chk("dma_data", dwd, e[31:0]);
    end
  end
  initial begin
    void'($urandom(32'hC3BF));
    reset_dut();
    bus(0, receive_descriptor_pointer_pkg::OFF_RECEIVE_DESCRIPTOR_POINTER, 32'h0);
    bus(1, receive_descriptor_pointer_pkg::OFF_RECEIVE_DESCRIPTOR_POINTER, 32'h1000_0007);
    bus(0, receive_descriptor_pointer_pkg::OFF_RECEIVE_DESCRIPTOR_POINTER, 32'h1000_0004);
    bus(0, 8'h7C, 32'h0);
    // list of two descriptors, the second ends it
    i_mem.link[32'h1000_0004] = 32'h2000_0000;
    bus(1, receive_descriptor_pointer_pkg::OFF_CMD, RXE_W);
    send(2, 32'h1000_0004);
    send(1, 32'h2000_0000);
    settle();
    bus(0, receive_descriptor_pointer_pkg::OFF_RECEIVE_DESCRIPTOR_POINTER, 32'h2000_0000);
    i_mem.link[32'h2000_0000] = 32'h3000_0000;
    mq.push_back({32'h2000_0000, 32'h0});
    bus(1, receive_descriptor_pointer_pkg::OFF_CMD, RXE_W);
    settle();
    bus(0, receive_descriptor_pointer_pkg::OFF_RECEIVE_DESCRIPTOR_POINTER, 32'h3000_0000);
    // second reset, then silent mode fills the fifo
    reset_dut();
    bus(0, receive_descriptor_pointer_pkg::OFF_RECEIVE_DESCRIPTOR_POINTER, 32'h0);
    bus(1, receive_descriptor_pointer_pkg::OFF_RECEIVE_DESCRIPTOR_POINTER, 32'h0);
    bus(1, receive_descriptor_pointer_pkg::OFF_CMD, RXE_W);
    chk("silent", sil, 1);
    send(receive_descriptor_pointer_pkg::FIFO_DEPTH, 32'h4000_0000);
    @(negedge clk);
    chk("ready_full", fr, 0);
    repeat (20) @(posedge clk);
    chk("held", mq.size(), receive_descriptor_pointer_pkg::FIFO_DEPTH + 1);
    bus(1, receive_descriptor_pointer_pkg::OFF_RECEIVE_DESCRIPTOR_POINTER, 32'h4000_0000);
    bus(1, receive_descriptor_pointer_pkg::OFF_CMD, RXE_W);
    settle();
    chk("silent_off", sil, 0);
    stop_test();
  end
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
endmodule : receive_descriptor_pointer_top_tb_top
